/* File: verilog/asr_pkg.sv */
package asr_pkg;
    // result width and transfer framing
    localparam int RES_BITS = 10;            // bits of one conversion result
    localparam int MAX_CLKS = 16;            // longest legal transfer
    localparam int SAMPLE_START_EDGE = 3;    // sampling begins on this falling edge
    localparam int HANDOFF_EDGE = 10;        // sample held, conversion starts
    localparam int CLK_MHZ = 50;             // system clock rate
    // times in nanoseconds as printed
    localparam int FAST_WINDOW_NS = 21000;   // fast/slow boundary after tenth edge
    localparam int SEL_HOLD_NS = 1425;       // select level must hold this long
    localparam int SYNC_LOSS_NS = 9500;      // eleventh rise must come within this
    localparam int CONV_TIME_NS = 20000;     // internal conversion time, inside fast window
    // cycle counts: least times round up, longest round down
    localparam int SEL_HOLD_CYC = (SEL_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int FAST_WINDOW_CYC = (FAST_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int SYNC_LOSS_CYC = (SYNC_LOSS_NS * CLK_MHZ) / 1000;
    localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
    // sequencer states, gray along idle->shift->convert->tail
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_SHIFT = 2'b01,
        ASR_CONV = 2'b11,
        ASR_TAIL = 2'b10
    } asr_state_e;
endpackage

/* File: verilog/asr_sar.sv */
// internal converter: runs on the system clock once handed control
module asr_sar
    import asr_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC  // cycles of one conversion
) (
    input wire logic clk_sys_in,                   // system clock
    input wire logic rstn_in,                      // async reset, active low
    input wire logic start_in,                     // one-cycle start pulse
    input wire logic [RES_BITS-1:0] sample_in,     // held sample code
    output logic busy_out,                         // conversion in progress
    output logic done_out,                         // one-cycle completion pulse
    output logic [RES_BITS-1:0] result_out         // output data register
);
    logic [15:0] cnt_reg; // conversion cycle count

    // count down the conversion, then load the result register
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= 16'h0000;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            result_out <= '0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                cnt_reg <= 16'(CONV_CYCLES);
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (cnt_reg == 16'h0001) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                    result_out <= sample_in;
                end
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end
endmodule // asr_sar

/* File: verilog/asr_readout.sv */
// Summary of operation
// - select high: ignore clock, output high-z
// - select low: enable clock, drive output
// - first ten clocks time the sampling
// - toggled modes: MSB at select fall
// - fast continuous: MSB within 21 us
// - slow continuous: MSB after sixteenth fall
// - nine more bits on next falls
// - conversion needs at least ten clocks
// - tenth fall drives output low
// - select edge valid after 1.425 us
// - eleventh rise within 9.5 us
// - done within 21 us: fast mode
// - done after 21 us: slow mode
// - select rise: high-z, clock disabled
// - select fall resets counters, control
// - sample from third to tenth fall
// - select fall aborts, keeps result; here a conversion already running still completes and loads it
// - tenth fall hands off to controller
module asr_readout
    import asr_pkg::*;
#(
    parameter int SEL_HOLD = SEL_HOLD_CYC,       // select debounce cycles
    parameter int FAST_WIN = FAST_WINDOW_CYC,    // fast window cycles
    parameter int SYNC_WIN = SYNC_LOSS_CYC,      // eleventh-rise limit cycles
    parameter int CONV_CYCLES = CONV_CYC         // conversion cycles
) (
    input wire logic clk_sys_in,                 // system clock, 50 MHz
    input wire logic rstn_in,                    // async reset, active low
    input wire logic sel_n_in,                   // chip select pin, active low
    input wire logic sclk_in,                    // shift clock pin from host
    input wire logic [RES_BITS-1:0] analog_code_in, // digitised analog input
    output logic dout_out,                       // result data pin level
    output logic dout_oe_out,                    // result pin drive enable
    output logic sampling_out,                   // sampling window open
    output logic fast_mode_out,                  // last transfer was fast
    output logic sync_lost_out                   // eleventh rise came too late
);
    logic [2:0] sel_sync_reg;    // select synchroniser
    logic [2:0] clk_sync_reg;    // shift clock synchroniser
    logic sel_stable_reg;        // debounced select level
    logic clk_level_reg;         // filtered shift clock level
    logic [15:0] hold_cnt_reg;   // select hold counter
    logic sel_fall, sel_rise, sclk_fall, sclk_rise; // edge events
    logic [4:0] edge_cnt_reg;    // falling edges this transfer
    logic [RES_BITS-1:0] shift_reg; // outgoing result bits
    logic [15:0] win_cnt_reg;    // cycles since tenth fall
    logic active;                // clock enabled, select low
    asr_state_e state_reg;       // sequencer state
    logic conv_start_reg;        // handoff pulse
    logic [RES_BITS-1:0] sample_reg; // held sample
    logic conv_busy, conv_done;  // converter status
    logic [RES_BITS-1:0] result; // output data register

    // three-stage synchronisers; stages 2 and 3 compared
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_sync_reg <= 3'b111;
            clk_sync_reg <= 3'b000;
            clk_level_reg <= 1'b0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[1:0], sel_n_in};
            clk_sync_reg <= {clk_sync_reg[1:0], sclk_in};
            if (clk_sync_reg[1] == clk_sync_reg[2]) begin
                clk_level_reg <= clk_sync_reg[2];
            end
        end
    end

    // select only counts once held for the minimum time
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_cnt_reg <= 16'h0000;
            sel_stable_reg <= 1'b1;
        end else if (sel_sync_reg[1] != sel_sync_reg[2]
                || sel_sync_reg[2] == sel_stable_reg) begin
            hold_cnt_reg <= 16'h0000;
        end else if (hold_cnt_reg == 16'(SEL_HOLD - 1)) begin
            sel_stable_reg <= sel_sync_reg[2];
            hold_cnt_reg <= 16'h0000;
        end else begin
            hold_cnt_reg <= hold_cnt_reg + 16'h0001;
        end
    end

    assign sel_fall = sel_stable_reg && !sel_sync_reg[2] && hold_cnt_reg == 16'(SEL_HOLD - 1)
                      && sel_sync_reg[1] == sel_sync_reg[2];
    assign sel_rise = !sel_stable_reg && sel_sync_reg[2] && hold_cnt_reg == 16'(SEL_HOLD - 1)
                      && sel_sync_reg[1] == sel_sync_reg[2];
    // clock edges ignored unless select is low
    assign active = !sel_stable_reg;
    assign sclk_fall = active && clk_level_reg && clk_sync_reg[1] == clk_sync_reg[2]
                       && !clk_sync_reg[2];
    assign sclk_rise = active && !clk_level_reg && clk_sync_reg[1] == clk_sync_reg[2]
                       && clk_sync_reg[2];

    // transfer sequencer: edge count, window timer, mode decision
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ASR_IDLE;
            edge_cnt_reg <= 5'd0;
            win_cnt_reg <= 16'h0000;
            conv_start_reg <= 1'b0;
            sample_reg <= '0;
            sampling_out <= 1'b0;
            fast_mode_out <= 1'b1;
            sync_lost_out <= 1'b0;
        end else begin
            conv_start_reg <= 1'b0;
            if (sel_fall || sel_rise) begin
                // abort any cycle here; a conversion already running in u_sar still loads the output register
                state_reg <= sel_fall ? ASR_SHIFT : ASR_IDLE;
                edge_cnt_reg <= 5'd0;
                win_cnt_reg <= 16'h0000;
                sampling_out <= 1'b0;
                sync_lost_out <= 1'b0;
            end else if (active) begin
                if (state_reg != ASR_SHIFT && win_cnt_reg != 16'hffff) begin
                    win_cnt_reg <= win_cnt_reg + 16'h0001;
                end
                if (sclk_fall && !sync_lost_out) begin
                    edge_cnt_reg <= (edge_cnt_reg == 5'(MAX_CLKS)) ? 5'd1
                                    : edge_cnt_reg + 5'd1;
                    if (edge_cnt_reg == 5'(SAMPLE_START_EDGE - 1)) begin
                        sampling_out <= 1'b1;
                    end
                    if (edge_cnt_reg == 5'(HANDOFF_EDGE - 1)) begin
                        // sample held, converter takes over
                        sampling_out <= 1'b0;
                        sample_reg <= analog_code_in;
                        conv_start_reg <= 1'b1;
                        state_reg <= ASR_CONV;
                        win_cnt_reg <= 16'h0000;
                    end
                    if (edge_cnt_reg == 5'(MAX_CLKS - 1)) begin
                        // transfer end decides fast or slow
                        fast_mode_out <= win_cnt_reg < 16'(FAST_WIN);
                        state_reg <= ASR_SHIFT;
                        edge_cnt_reg <= 5'd0;
                    end
                end
                if (sclk_rise && edge_cnt_reg == 5'(HANDOFF_EDGE)
                        && win_cnt_reg > 16'(SYNC_WIN)) begin
                    sync_lost_out <= 1'b1;
                end
                // ten-clock continuous transfer: new cycle after window
                // a lost transfer stays parked until select toggles
                if (state_reg == ASR_CONV && edge_cnt_reg == 5'(HANDOFF_EDGE)
                        && win_cnt_reg == 16'(FAST_WIN - 1) && !sync_lost_out) begin
                    state_reg <= ASR_TAIL;
                    fast_mode_out <= 1'b1;
                end
                if (state_reg == ASR_TAIL) begin
                    state_reg <= ASR_SHIFT;
                    edge_cnt_reg <= 5'd0;
                end
            end
        end
    end

    // output shifter: MSB loaded on cycle start, bits on falling edges
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_reg <= '0;
            dout_out <= 1'b0;
            dout_oe_out <= 1'b0;
        end else begin
            // drive starts together with the msb, not a cycle after it
            dout_oe_out <= (active || sel_fall) && !sel_rise;
            if (sel_fall || (state_reg == ASR_TAIL)
                    || (active && sclk_fall && edge_cnt_reg == 5'(MAX_CLKS - 1))) begin
                shift_reg <= result;
                dout_out <= result[RES_BITS-1];
            end else if (active && sclk_fall && !sync_lost_out) begin
                if (edge_cnt_reg == 5'(HANDOFF_EDGE - 1)) begin
                    dout_out <= 1'b0;
                end else if (edge_cnt_reg < 5'(HANDOFF_EDGE - 1)) begin
                    dout_out <= shift_reg[RES_BITS-2];
                    shift_reg <= {shift_reg[RES_BITS-2:0], 1'b0};
                end
            end
        end
    end

    asr_sar #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_sar (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .start_in(conv_start_reg),
        .sample_in(sample_reg),
        .busy_out(conv_busy),
        .done_out(conv_done),
        .result_out(result)
    );

    // pin is never driven while select is settled high
    a_hiz_when_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        sel_stable_reg && !$past(active) |-> !dout_oe_out)
        else $error("result pin driven while deselected");
    a_drive_on_sel: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        sel_fall |=> dout_oe_out)
        else $error("pin not driven after select fall");
    // compare against the result as it stood when select fell
    a_msb_at_sel: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        sel_fall |=> dout_out == $past(result[RES_BITS-1]))
        else $error("msb not presented at select fall");
    a_low_after_ten: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        sclk_fall && !sync_lost_out && edge_cnt_reg == 5'd9 |=> !dout_out)
        else $error("output not low after tenth edge");
    a_handoff_pulse: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        conv_start_reg |-> ##1 conv_busy)
        else $error("converter did not start");
    a_release_pin: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        sel_rise |=> !dout_oe_out ##1 !dout_oe_out)
        else $error("pin still driven after select rise");
    a_sample_window: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        $rose(sampling_out) |-> $past(edge_cnt_reg) == 5'd2)
        else $error("sampling opened on wrong edge");
    // only a conversion finishing on that very edge may update the register
    a_abort_keeps: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        sel_fall |=> $stable(result) || conv_done)
        else $error("select fall changed the result");
    a_cont_msb: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        state_reg == ASR_TAIL |=> dout_out == $past(result[RES_BITS-1]))
        else $error("msb missing in continuous mode");
endmodule // asr_readout

/* File: sim/asr_host.sv */
// host serial port model, master of select and shift clock
module asr_host (
    input wire logic clk_in,        // system clock
    input wire logic dout_in,       // result pin level
    input wire logic oe_in,         // result pin drive enable
    input wire logic samp_in,       // sampling window flag
    output logic sel_n_out,         // select, active low
    output logic sclk_out,          // shift clock, idles low
    output logic [15:0] word_out,   // bits read, last in at bit 0
    output logic [15:0] samp_out,   // window flag per clock
    output logic valid_out          // one-cycle result strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_bit; // last level seen; a released pin shows its inverse
    initial begin
        sel_n_out = 1'b1;
        sclk_out = 1'b0;
        valid_out = 1'b0;
        last_bit = 1'b0;
    end
    // wait a number of system cycles
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // one transfer of n shift clocks
    task automatic xfer(input int n, input bit tog, input bit slow, input bit late);
        int half;
        word_out <= 16'h0000;
        samp_out <= 16'h0000;
        if (sel_n_out) begin
            // pulses while deselected must be ignored
            repeat (3) begin
                tick(4);
                sclk_out <= 1'b1;
                tick(4);
                sclk_out <= 1'b0;
            end
            tick(4);
            sel_n_out <= 1'b0; // held low through the transfer
            tick(20); // level held past debounce
        end
        for (int k = 1; k <= n; k++) begin // 10 to 16 clocks
            half = (slow && k > 11) ? 12 : 4;
            if (late && k == 11) tick(40); // eleventh rise too late on purpose
            sclk_out <= 1'b1;
            tick(half - 1);
            @(negedge clk_in);
            last_bit = oe_in ? dout_in : ~last_bit; // read while clock is high
            word_out <= {word_out[14:0], last_bit};
            samp_out[k-1] <= samp_in;
            @(posedge clk_in);
            sclk_out <= 1'b0;
            tick(half);
        end
        if (tog) begin
            tick(2);
            sel_n_out <= 1'b1; // toggled modes deselect between transfers
        end
        tick(80); // quiet spell of 80 cycles, past the bench's 60-cycle fast window after tenth fall
        valid_out <= 1'b1;
        tick(1);
        valid_out <= 1'b0;
    endtask
endmodule // asr_host

/* File: sim/asr_readout_test.sv */
// bench: mode table, then a lost-sync transfer and recovery
module asr_readout_test;
    timeunit 1ns;
    timeprecision 1ns;
    import asr_pkg::*;
    logic clk_sys_in, rstn_in, sel_n, sclk, dout, dout_oe, sampling;
    logic fast_mode, sync_lost, valid, lost_seen;
    logic [RES_BITS-1:0] analog_code, prev_code, new_code;
    logic [15:0] word, samp;
    logic [15:0] exp_word_q[$];
    logic [15:0] exp_samp_q[$];
    int bad_count, samples_checked, seed;
    int n_tab[7] = '{10, 12, 16, 10, 10, 16, 16}; // clocks per transfer
    bit tog_tab[7] = '{1, 1, 1, 0, 0, 0, 0}; // deselect between transfers
    bit slow_tab[7] = '{0, 0, 1, 0, 0, 0, 1}; // stretch tail past window
    // short counts keep the run brief
    asr_readout #(.SEL_HOLD(8), .FAST_WIN(60), .SYNC_WIN(30), .CONV_CYCLES(40)) DUT (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sel_n_in(sel_n), .sclk_in(sclk),
        .analog_code_in(analog_code), .dout_out(dout), .dout_oe_out(dout_oe),
        .sampling_out(sampling), .fast_mode_out(fast_mode), .sync_lost_out(sync_lost));
    asr_host host (.clk_in(clk_sys_in), .dout_in(dout), .oe_in(dout_oe), .samp_in(sampling),
        .sel_n_out(sel_n), .sclk_out(sclk), .word_out(word), .samp_out(samp), .valid_out(valid));
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // oldest note against each word the host reports
    always @(posedge clk_sys_in) begin
        if (valid === 1'b1 && exp_word_q.size() > 0) begin
            check(word, exp_word_q.pop_front());
            check(samp, exp_samp_q.pop_front());
        end
    end
    // any sync loss leaves a mark
    always @(posedge clk_sys_in) begin
        if (sync_lost === 1'b1) lost_seen <= 1'b1;
    end
    // one transfer with expectations noted first
    task automatic run(input int n, input bit tog, input bit slow, input bit late);
        exp_word_q.push_back(16'(prev_code) << (n - 10)); // previous result, zero tail
        exp_samp_q.push_back(16'h03F8); // window from third to tenth fall
        new_code = RES_BITS'($urandom());
        @(posedge clk_sys_in);
        analog_code <= new_code;
        host.xfer(n, tog, slow, late);
        prev_code = new_code;
        if (n == 16 && !late) check(16'(fast_mode), 16'(!slow));
        if (tog) check(16'(dout_oe), 16'h0000);
    endtask
    initial begin
        rstn_in = 1'b0;
        analog_code = '0;
        prev_code = '0;
        lost_seen = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        seed = $urandom(98018);
        repeat (3) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 7; i++) run(n_tab[i], tog_tab[i], slow_tab[i], 1'b0);
        check(16'(lost_seen), 16'h0000);
        run(16, 1'b1, 1'b0, 1'b1);
        check(16'(lost_seen), 16'h0001);
        run(10, 1'b1, 1'b0, 1'b0); // select toggle restores operation
        check(16'(sync_lost), 16'h0000);
        repeat (5) @(posedge clk_sys_in);
        results();
    end
    // watchdog well past the expected run length
    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule // asr_readout_test
